// ===== logic/freefall_motion_event_detect.sv
// Behaviour
// - Select bit picks freefall or motion
// - All axis enables clear disables detector
// - Latch and select bits give four modes
// - Freefall active flag after debounce completes
// - Only enabled axes join the condition
// - Mode 0 counter decrements before clearing
// - Mode 1 clears flag, rearms after delay
// - Freefall unlatched read keeps flag
// - Axis flags follow raw status when enabled
// - Latched freefall holds flag until read
// - Latched read clears flag and counter
// - Latched axis flags freeze until read
// - Motion flag after debounce count reached
// - Motion clearing mode drops flag immediately
// - Motion unlatched read changes nothing
// - Debounce mode bit resets to one
// - Motion ORs axes, freefall ANDs them
// - Motion above threshold, freefall at/below
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
module freefall_motion_event_detect (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic clkEn,
  // Sample stream at output data rate
  input wire logic sampleValid,
  input wire logic signed [ffm_pkg::SAMPLE_W-1:0] xSample,
  input wire logic signed [ffm_pkg::SAMPLE_W-1:0] ySample,
  input wire logic signed [ffm_pkg::SAMPLE_W-1:0] zSample,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Status
  output logic eventActive,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rstMeta_r;
  logic rstSync_r;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSync_r <= rstMeta_r;
    end
  end
  logic rstn;
  assign rstn = rstSync_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  ffm_pkg::ffm_bus_t bus;
  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [7:0] evtCfg_r;
  logic [7:0] orientCfg_r;
  logic [ffm_pkg::THS_W-1:0] evtThs_r;
  logic [ffm_pkg::CNT_W-1:0] evtCnt_r;
  logic [1:0] intMask_r;

  // Write strobes, one per register; unmapped writes fall through
  logic wrEvtCfg;
  logic wrOrientCfg;
  logic wrEvtThs;
  logic wrEvtCnt;
  logic wrIntMask;
  logic wrIntStat;
  assign wrEvtCfg = clkEn && bus.wr && hit(bus.addr, ffm_pkg::EVT_CFG_ADDR);
  assign wrOrientCfg = clkEn && bus.wr && hit(bus.addr, ffm_pkg::ORIENT_CFG_ADDR);
  assign wrEvtThs = clkEn && bus.wr && hit(bus.addr, ffm_pkg::EVT_THS_ADDR);
  assign wrEvtCnt = clkEn && bus.wr && hit(bus.addr, ffm_pkg::EVT_CNT_ADDR);
  assign wrIntMask = clkEn && bus.wr && hit(bus.addr, ffm_pkg::INT_MASK_ADDR);
  assign wrIntStat = clkEn && bus.wr && hit(bus.addr, ffm_pkg::INT_STAT_ADDR);

  // Reserved low bits always read zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evtCfg_r <= ffm_pkg::EVT_CFG_RST;
    end else if (wrEvtCfg) begin
      evtCfg_r <= {bus.wdata[ffm_pkg::CFG_LATCH_BIT:ffm_pkg::CFG_XEN_BIT], 3'h0};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      orientCfg_r <= ffm_pkg::ORIENT_CFG_RST;
    end else if (wrOrientCfg) begin
      orientCfg_r <= {bus.wdata[ffm_pkg::ORIENT_DBMODE_BIT:ffm_pkg::ORIENT_EN_BIT], 6'h00};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evtThs_r <= ffm_pkg::EVT_THS_RST;
    end else if (wrEvtThs) begin
      evtThs_r <= bus.wdata[ffm_pkg::THS_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      evtCnt_r <= ffm_pkg::EVT_CNT_RST;
    end else if (wrEvtCnt) begin
      evtCnt_r <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intMask_r <= ffm_pkg::INT_RST;
    end else if (wrIntMask) begin
      intMask_r <= bus.wdata[1:0];
    end
  end

  ffm_pkg::ffm_cfg_t cfg;
  assign cfg = '{latchEn: evtCfg_r[ffm_pkg::CFG_LATCH_BIT],
                 motionSel: evtCfg_r[ffm_pkg::CFG_MOTION_BIT],
                 axisEn: {evtCfg_r[ffm_pkg::CFG_ZEN_BIT], evtCfg_r[ffm_pkg::CFG_YEN_BIT],
                          evtCfg_r[ffm_pkg::CFG_XEN_BIT]}};
  logic dbClearMode;
  assign dbClearMode = orientCfg_r[ffm_pkg::ORIENT_DBMODE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Per-axis comparison
  logic [ffm_pkg::AXES-1:0] axHigh;
  logic [ffm_pkg::AXES-1:0] axNeg;
  logic signed [ffm_pkg::SAMPLE_W-1:0] samples [ffm_pkg::AXES];
  assign samples[0] = xSample;
  assign samples[1] = ySample;
  assign samples[2] = zSample;

  for (genvar i = 0; i < ffm_pkg::AXES; i++) begin : g_axis
    ffm_axis_cmp u_cmp (
      .sample(samples[i]),
      .threshold(evtThs_r),
      .high(axHigh[i]),
      .negative(axNeg[i])
    );
  end

  // Raw condition; a disabled axis is neutral in AND and OR
  logic anyEn;
  logic cond;
  assign anyEn = |cfg.axisEn;
  always_comb begin
    if (!anyEn) begin
      cond = 1'b0;
    end else if (cfg.motionSel) begin
      cond = |(axHigh & cfg.axisEn);
    end else begin
      cond = &(~axHigh | ~cfg.axisEn);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debounce and event-active flag
  logic srcRead;
  assign srcRead = clkEn && bus.rd && hit(bus.addr, ffm_pkg::EVT_SRC_ADDR);

  ffm_pkg::ffm_state_t state_r;
  logic [ffm_pkg::CNT_W-1:0] dbCnt_r;
  logic active_r;
  logic [ffm_pkg::CNT_W-1:0] dbCnt_nxt;
  logic active_nxt;
  ffm_pkg::ffm_state_t state_nxt;

  always_comb begin
    dbCnt_nxt = dbCnt_r;
    active_nxt = active_r;
    state_nxt = state_r;
    case (state_r)
      ffm_pkg::FFM_IDLE: begin
        if (anyEn) begin
          state_nxt = ffm_pkg::FFM_ARMED;
        end
      end
      ffm_pkg::FFM_ARMED: begin
        if (sampleValid) begin
          if (cond) begin
            if (dbCnt_r >= evtCnt_r) begin
              active_nxt = 1'b1;
            end else begin
              dbCnt_nxt = dbCnt_r + 8'h01;
            end
          end else if (dbClearMode) begin
            dbCnt_nxt = 8'h00;
            if (!cfg.latchEn) begin
              active_nxt = 1'b0;
            end
          end else if (dbCnt_r != 8'h00) begin
            dbCnt_nxt = dbCnt_r - 8'h01;
          end else if (!cfg.latchEn) begin
            active_nxt = 1'b0;
          end
        end
        if (active_nxt && cfg.latchEn) begin
          state_nxt = ffm_pkg::FFM_HOLD;
        end
      end
      ffm_pkg::FFM_HOLD: begin
        // Held until the source read; counter frozen meanwhile
        if (!cfg.latchEn) begin
          state_nxt = ffm_pkg::FFM_ARMED;
        end
      end
      default: begin
        state_nxt = ffm_pkg::FFM_IDLE;
      end
    endcase
    // Latched read clears flag and counter; unlatched read is a no-op
    if (srcRead && cfg.latchEn) begin
      active_nxt = 1'b0;
      dbCnt_nxt = 8'h00;
      if (state_r == ffm_pkg::FFM_HOLD) begin
        state_nxt = ffm_pkg::FFM_ARMED;
      end
    end
    if (!anyEn) begin
      state_nxt = ffm_pkg::FFM_IDLE;
      active_nxt = 1'b0;
      dbCnt_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ffm_pkg::FFM_IDLE;
    end else if (clkEn) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dbCnt_r <= 8'h00;
    end else if (clkEn) begin
      dbCnt_r <= dbCnt_nxt;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_r <= 1'b0;
    end else if (clkEn) begin
      active_r <= active_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-axis flags
  logic [5:0] axFlags_r;
  logic [5:0] axRaw;
  always_comb begin
    axRaw = 6'h00;
    for (int i = 0; i < ffm_pkg::AXES; i++) begin
      axRaw[2*i+1] = axHigh[i] & cfg.axisEn[i];
      axRaw[2*i] = axHigh[i] & axNeg[i] & cfg.axisEn[i];
    end
  end

  // Frozen while the latched flag stands; the read reopens tracking
  logic axTrack;
  assign axTrack = !(cfg.latchEn && active_r) || srcRead;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      axFlags_r <= 6'h00;
    end else if (clkEn && axTrack) begin
      axFlags_r <= axRaw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, set wins
  logic [1:0] intStat_r;
  logic [1:0] intSet;
  logic [1:0] intClr;
  logic [1:0] intStat_nxt;
  always_comb begin
    intSet = 2'h0;
    intSet[ffm_pkg::STAT_RISE_BIT] = ~active_r & active_nxt;
    intSet[ffm_pkg::STAT_FALL_BIT] = active_r & ~active_nxt;
  end
  assign intClr = wrIntStat ? bus.wdata[1:0] : 2'h0;
  // Set wins so an edge in the clearing cycle is never lost
  assign intStat_nxt = (intStat_r & ~intClr) | intSet;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      intStat_r <= ffm_pkg::INT_RST;
    end else if (clkEn) begin
      intStat_r <= intStat_nxt;
    end
  end

  // Irq from the next status keeps it in step with the bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else if (clkEn) begin
      irq <= |(intStat_nxt & intMask_r);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eventActive <= 1'b0;
    end else if (clkEn) begin
      eventActive <= active_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe
  logic [7:0] rdMux;
  always_comb begin
    case (bus.addr)
      ffm_pkg::ORIENT_CFG_ADDR: rdMux = orientCfg_r;
      ffm_pkg::EVT_CFG_ADDR: rdMux = evtCfg_r;
      ffm_pkg::EVT_SRC_ADDR: rdMux = {active_r, 1'b0, axFlags_r};
      ffm_pkg::EVT_THS_ADDR: rdMux = {1'b0, evtThs_r};
      ffm_pkg::EVT_CNT_ADDR: rdMux = evtCnt_r;
      ffm_pkg::INT_STAT_ADDR: rdMux = {6'h00, intStat_r};
      ffm_pkg::INT_MASK_ADDR: rdMux = {6'h00, intMask_r};
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      regRdata <= 8'h00;
    end else if (clkEn) begin
      regRdata <= bus.rd ? rdMux : 8'h00;
    end
  end

endmodule

// ===== logic/ffm_pkg.sv
package ffm_pkg;

  // Register offsets
  localparam logic [7:0] ORIENT_CFG_ADDR = 8'h11;
  localparam logic [7:0] EVT_CFG_ADDR = 8'h15;
  localparam logic [7:0] EVT_SRC_ADDR = 8'h16;
  localparam logic [7:0] EVT_THS_ADDR = 8'h17;
  localparam logic [7:0] EVT_CNT_ADDR = 8'h18;
  localparam logic [7:0] INT_STAT_ADDR = 8'h1A;
  localparam logic [7:0] INT_MASK_ADDR = 8'h1B;

  // Field positions
  localparam int CFG_LATCH_BIT = 7;
  localparam int CFG_MOTION_BIT = 6;
  localparam int CFG_ZEN_BIT = 5;
  localparam int CFG_YEN_BIT = 4;
  localparam int CFG_XEN_BIT = 3;
  localparam int SRC_ACTIVE_BIT = 7;
  localparam int ORIENT_DBMODE_BIT = 7;
  localparam int ORIENT_EN_BIT = 6;
  localparam int STAT_RISE_BIT = 0;
  localparam int STAT_FALL_BIT = 1;

  // Reset values
  localparam logic [7:0] EVT_CFG_RST = 8'h00;
  localparam logic [7:0] ORIENT_CFG_RST = 8'h80;
  localparam logic [6:0] EVT_THS_RST = 7'h00;
  localparam logic [7:0] EVT_CNT_RST = 8'h00;
  localparam logic [1:0] INT_RST = 2'h0;

  // Widths
  localparam int SAMPLE_W = 10;
  localparam int THS_W = 7;
  localparam int CNT_W = 8;
  localparam int AXES = 3;

  typedef struct packed {
    logic latchEn;
    logic motionSel;
    logic [2:0] axisEn;
  } ffm_cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ffm_bus_t;

  typedef enum logic [1:0] {
    FFM_IDLE,
    FFM_ARMED,
    FFM_HOLD
  } ffm_state_t;

endpackage

// ===== logic/ffm_axis_cmp.sv
`timescale 1ns/1ps
module ffm_axis_cmp (
  // Sample and threshold
  input wire logic signed [ffm_pkg::SAMPLE_W-1:0] sample,
  input wire logic [ffm_pkg::THS_W-1:0] threshold,
  // Result
  output logic high,
  output logic negative
);
  logic [ffm_pkg::SAMPLE_W-1:0] mag;

  // Threshold compared against upper magnitude bits
  always_comb begin
    mag = sample[ffm_pkg::SAMPLE_W-1] ? ffm_pkg::SAMPLE_W'(-sample) : sample;
    high = mag[ffm_pkg::SAMPLE_W-1:ffm_pkg::SAMPLE_W-1-ffm_pkg::THS_W] >
      {1'b0, threshold};
    negative = sample[ffm_pkg::SAMPLE_W-1];
  end
endmodule

// ===== testbench/ffm_event_monitor.sv
`timescale 1ns/1ps
module ffm_event_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Inputs
  input wire logic clkEn,
  input wire logic sampleValid,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  // Outputs
  input wire logic [7:0] regRdata,
  input wire logic eventActive,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  logic srcRd;
  logic latchMode_r;
  logic [2:0] srcRdHist_r;
  assign srcRd = regRd && clkEn && (regAddr == ffm_pkg::EVT_SRC_ADDR);
  // Latch only matters while some axis is enabled
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      latchMode_r <= 1'b0;
    end else if (regWr && clkEn && regAddr == ffm_pkg::EVT_CFG_ADDR) begin
      latchMode_r <= regWdata[7] && (regWdata[5:3] != 3'h0);
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      srcRdHist_r <= 3'h0;
    end else begin
      srcRdHist_r <= {srcRdHist_r[1:0], srcRd};
    end
  end
  ////////////////////////////////////////////////////////////
  a_rdata_idle: assert property ($past(clkEn) && !$past(regRd) |-> regRdata == 8'h00)
    else $error("read data not zero");
  a_src_layout: assert property ($past(srcRd) |-> !regRdata[6] && (!regRdata[0] || regRdata[1])
    && (!regRdata[2] || regRdata[3]) && (!regRdata[4] || regRdata[5]))
    else $error("bad source layout");
  a_rise_sample: assert property ($rose(eventActive) |->
    $past(sampleValid) || $past(sampleValid, 2) || $past(sampleValid, 3))
    else $error("flag rose without sample");
  a_latch_hold: assert property (latchMode_r && $fell(eventActive) |-> |srcRdHist_r)
    else $error("latched flag fell unread");
  a_latch_clear: assert property (latchMode_r && eventActive && srcRd |=> !eventActive)
    else $error("latched flag kept after read");
  a_unlatch_read: assert property (!latchMode_r && eventActive && srcRd && !sampleValid
    && !$past(sampleValid) && !$past(sampleValid, 2) |=> eventActive)
    else $error("read cleared flag");
  a_axes_off: assert property (regWr && clkEn && regAddr == ffm_pkg::EVT_CFG_ADDR
    && regWdata[5:3] == 3'h0 |-> ##3 !eventActive)
    else $error("flag with all axes off");
  a_mask_irq: assert property (regWr && clkEn && regAddr == ffm_pkg::INT_MASK_ADDR
    && regWdata == 8'h00 |-> ##2 !irq)
    else $error("irq with mask clear");
  a_clken_hold: assert property (!clkEn |=> $stable(eventActive) && $stable(irq))
    else $error("outputs moved while frozen");
endmodule
bind freefall_motion_event_detect ffm_event_monitor mon (.clk(clk), .resetn(resetn),
  .clkEn(clkEn), .sampleValid(sampleValid), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .eventActive(eventActive), .irq(irq));

// ===== testbench/freefall_motion_event_detect_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module freefall_motion_event_detect_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic sampleValid = 1'b0;
  logic signed [ffm_pkg::SAMPLE_W-1:0] xSample = '0, ySample = '0, zSample = '0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic eventActive;
  logic irq;
  int err_count = 0;
  int comparisons = 0;
  localparam logic [7:0] SRC = ffm_pkg::EVT_SRC_ADDR;
  localparam logic [7:0] CFG = ffm_pkg::EVT_CFG_ADDR;
  // Magnitudes 50 and 5 after the two-bit drop, threshold 16
  localparam logic signed [9:0] H = 10'sh0C8;
  localparam logic signed [9:0] N = 10'sh338;
  localparam logic signed [9:0] L = 10'sh014;
  logic [7:0] zAddr [7] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h1A, 8'h1B, 8'h00};
  always #2.5 clk = ~clk;
  freefall_motion_event_detect uut (.clk(clk), .resetn(resetn), .clkEn(clkEn),
    .sampleValid(sampleValid), .xSample(xSample), .ySample(ySample), .zSample(zSample),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .eventActive(eventActive), .irq(irq));
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    `CHK(regRdata, e)
  endtask
  // Gap after each sample lets the debounce result settle
  task automatic smp(input int n, input logic signed [9:0] x, y, z);
    repeat (n) begin
      @(posedge clk);
      xSample <= x;
      ySample <= y;
      zSample <= z;
      sampleValid <= 1'b1;
      @(posedge clk);
      sampleValid <= 1'b0;
      repeat (3) @(posedge clk);
    end
    @(negedge clk);
  endtask
  task automatic ev(input logic e);
    @(negedge clk);
    `CHK(eventActive, e)
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #20000;
    err_count++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h11, 8'h80);
    foreach (zAddr[i]) rd(zAddr[i], 8'h00);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00);
    $display("test reset done");
    wr(8'h17, 8'h10);
    wr(8'h18, 8'h02);
    wr(CFG, 8'h48);
    smp(1, L, H, L);
    rd(SRC, 8'h00);
    smp(1, N, L, L);
    rd(SRC, 8'h03);
    ev(1'b0);
    smp(2, N, L, L);
    rd(SRC, 8'h83);
    rd(SRC, 8'h83);
    smp(1, L, L, L);
    rd(SRC, 8'h00);
    wr(8'h18, 8'h00);
    wr(CFG, 8'h78);
    smp(1, L, L, H);
    rd(SRC, 8'hA0);
    @(posedge clk);
    clkEn <= 1'b0;
    repeat (4) @(posedge clk);
    clkEn <= 1'b1;
    ev(1'b1);
    $display("test motion done");
    wr(CFG, 8'h00);
    wr(8'h11, 8'h00);
    wr(8'h18, 8'h02);
    ev(1'b0);
    wr(CFG, 8'h38);
    smp(3, L, L, L);
    ev(1'b1);
    smp(1, H, L, L);
    rd(SRC, 8'h82);
    rd(SRC, 8'h82);
    smp(2, H, L, L);
    ev(1'b0);
    wr(8'h11, 8'h80);
    smp(3, L, L, L);
    ev(1'b1);
    smp(1, L, H, L);
    ev(1'b0);
    smp(1, L, L, L);
    ev(1'b0);
    smp(2, L, L, L);
    ev(1'b1);
    $display("test freefall done");
    wr(CFG, 8'h00);
    wr(CFG, 8'hB8);
    smp(3, L, L, L);
    ev(1'b1);
    smp(1, N, L, L);
    ev(1'b1);
    rd(SRC, 8'h80);
    smp(1, L, L, L);
    ev(1'b0);
    rd(SRC, 8'h00);
    smp(1, N, L, L);
    rd(SRC, 8'h03);
    $display("test latched done");
    wr(8'h1A, 8'h03);
    wr(8'h1B, 8'h01);
    smp(3, L, L, L);
    `CHK(irq, 1'b1)
    rd(8'h1A, 8'h01);
    rd(SRC, 8'h80);
    rd(8'h1A, 8'h03);
    wr(8'h1B, 8'h00);
    rd(8'h1A, 8'h03);
    `CHK(irq, 1'b0)
    wr(8'h1A, 8'h01);
    wr(8'h1B, 8'h03);
    rd(8'h1A, 8'h02);
    `CHK(irq, 1'b1)
    wr(8'h1A, 8'h02);
    rd(8'h1A, 8'h00);
    `CHK(irq, 1'b0)
    smp(3, L, L, L);
    ev(1'b1);
    wr(CFG, 8'h80);
    smp(2, L, L, L);
    ev(1'b0);
    $display("test interrupt done");
    print_verdict();
  end
endmodule
